/* File: hdl/branch_pkg.sv */
// package: encodings, register map and types for the signed conditional branch unit
package branch_pkg;

	// instruction word layout
	localparam int CLASS_MSB    = 15;              // class field, top bit
	localparam int CLASS_LSB    = 13;              // class field, low bit
	localparam int OPF_MSB      = 12;              // operation field, top bit
	localparam int OPF_LSB      = 9;               // operation field, low bit
	localparam int DELAY_BIT    = 8;               // delayed-branch flag position
	localparam int DISP_MSB     = 7;               // short displacement, top bit
	localparam int PAYLOAD_W    = 13;              // prefix payload width
	localparam int PAYLOAD_KEEP = 3;               // low payload bits dropped in the top prefix

	localparam logic [2:0] CLASS_BRANCH = 3'h0;    // class of the branch group
	localparam logic [3:0] OPF_GT       = 4'h4;    // 0x0800-0x09FF
	localparam logic [3:0] OPF_GE       = 4'h5;    // 0x0A00-0x0BFF
	localparam logic [3:0] OPF_LE       = 4'h7;    // 0x0E00-0x0FFF

	// prefix depth
	localparam logic [1:0] PFX_NONE = 2'h0;        // no prefix seen
	localparam logic [1:0] PFX_ONE  = 2'h1;        // one prefix seen
	localparam logic [1:0] PFX_TWO  = 2'h2;        // two prefixes seen

	// register map (byte offsets, word aligned)
	localparam logic [3:0] REG_STATUS      = 4'h0; // slot pending, busy, last outcome
	localparam logic [3:0] REG_LAST_TARGET = 4'h4; // last computed target
	localparam logic [3:0] REG_TAKEN_COUNT = 4'h8; // taken branches, any write clears
	localparam int         ST_SLOT_BIT     = 0;    // status: delay slot pending
	localparam int         ST_BUSY_BIT     = 1;    // status: second cycle of taken branch
	localparam int         ST_TAKEN_BIT    = 2;    // status: last branch was taken
	localparam logic [31:0] RESET_WORD     = 32'h0000_0000; // value of all registers after reset

	// condition flags from the status register
	typedef struct packed {
		logic n;                               // negative
		logic z;                               // zero
		logic v;                               // overflow
		logic c;                               // carry
	} flags_t;

	// redirect request toward the fetch stage
	typedef struct packed {
		logic        valid;                    // redirect this cycle
		logic [31:0] target;                   // new program counter
	} redirect_t;

endpackage

/* File: hdl/disp_former.sv */
// displacement former: short, one-prefix and two-prefix byte offsets
`timescale 1ns/100ps
module disp_former (
	// displacement sources
	input  wire logic [7:0]  short_displacement_i,   // half-word displacement from the opcode
	input  wire logic [1:0]  prefix_count_i,         // number of prefixes before the branch
	input  wire logic [12:0] prefix_hi_i,            // first of two prefixes
	input  wire logic [12:0] prefix_lo_i,            // last prefix seen
	// result
	output logic      [31:0] offset_o                // signed byte offset
);
	logic [31:0] short_off;                          // short form
	logic [21:0] mid_displacement;                   // one-prefix form
	logic [31:0] mid_off;                            // one-prefix form, widened
	logic [31:0] full_displacement;                  // two-prefix form

	// bit 0 is always zero: the displacement counts half-words
	assign short_off = {{23{short_displacement_i[7]}}, short_displacement_i, 1'b0}; // [RQ5] [RQ6]
	assign mid_displacement = {prefix_lo_i, short_displacement_i, 1'b0};             // [RQ9] [RQ6]
	assign mid_off = {{10{mid_displacement[21]}}, mid_displacement};                 // [RQ9]
	// top prefix loses its low three bits so the sum fits 32 bits exactly
	assign full_displacement = {prefix_hi_i[12:branch_pkg::PAYLOAD_KEEP], prefix_lo_i,
		short_displacement_i, 1'b0};                                             // [RQ10]

	// choose by prefix depth
	assign offset_o = (prefix_count_i == branch_pkg::PFX_TWO) ? full_displacement :
		(prefix_count_i == branch_pkg::PFX_ONE) ? mid_off : short_off;
endmodule // disp_former

/* File: hdl/signed_cond_branch_unit.sv */
// signed conditional branch unit: decode, condition, target, timing and slot masking
//
// Overview of operation
// RQ1: GE branches when N equals V.
// RQ2: GT branches when Z clear, N equals V.
// RQ3: LE branches when Z set or N differs V.
// RQ4: decode class, operation, delay bit, displacement.
// RQ5: short displacement sign-extended, doubled, added.
// RQ6: displacement counts half-words, bit0 zero.
// RQ7: plain branch: one cycle fail, two taken.
// RQ8: delayed branch always completes in one cycle.
// RQ9: one prefix gives offset bits 21..9.
// RQ10: two prefixes: first supplies bits 31..22.
// RQ11: delayed branch runs the slot first.
// RQ12: traps masked between branch and slot.
// RQ13: software puts only eligible slot instructions.
// RQ14: branches never change the status flags.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module signed_cond_branch_unit (
	// clock and reset
	input  wire logic                       clk_i,           // core clock, 100 MHz
	input  wire logic                       rstn_i,          // asynchronous reset, active low
	// instruction issue
	input  wire logic                       instr_valid_i,   // a non-prefix instruction issues
	input  wire logic [15:0]                instr_i,         // instruction word
	input  wire logic [31:0]                pc_i,            // address of the issued instruction
	input  wire branch_pkg::flags_t         flags_i,         // current condition flags
	input  wire logic                       prefix_valid_i,  // a prefix instruction issues
	input  wire logic [12:0]                prefix_payload_i,// its payload
	// core control
	output branch_pkg::redirect_t           redirect_o,      // program counter redirect
	output logic                            is_branch_o,     // issued word is one of ours
	output logic                            busy_o,          // hold issue: second cycle
	output logic                            trap_mask_o,     // block interrupts and exceptions
	output logic                            flags_we_o,      // status register write, never
	// register port
	input  wire logic [3:0]                 reg_addr_i,      // byte address
	input  wire logic [31:0]                reg_wdata_i,     // write data
	input  wire logic                       reg_we_i,        // write strobe
	input  wire logic                       reg_re_i,        // read strobe
	output logic      [31:0]                reg_rdata_o      // read data, one cycle later
);

	// control states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,                      // ready for a new instruction
		ST_TAKEN = 3'b010,                      // second cycle of a taken plain branch
		ST_SLOT  = 3'b100                       // waiting for the delay-slot instruction
	} state_t;

	state_t         state;                      // current state
	state_t         next_state;                 // next state
	logic [1:0]     prefix_count;               // prefixes collected so far
	logic [12:0]    prefix_hi;                  // older prefix payload
	logic [12:0]    prefix_lo;                  // newest prefix payload
	logic [31:0]    target;                     // held branch target
	logic           pend_taken;                 // delayed branch outcome awaiting the slot
	logic           last_taken;                 // outcome of the most recent branch
	logic [31:0]    taken_count;                // taken branch counter
	logic [31:0]    rdata;                      // registered read data

	// condition evaluation, shared by decode and nothing wider
	function automatic logic cond_met(input logic [3:0] opf, input branch_pkg::flags_t f);
		logic sgn_ge;
		sgn_ge = (f.n == f.v);
		case (opf)
			branch_pkg::OPF_GE: cond_met = sgn_ge;              // [RQ1]
			branch_pkg::OPF_GT: cond_met = !f.z && sgn_ge;      // [RQ2]
			branch_pkg::OPF_LE: cond_met = f.z || !sgn_ge;      // [RQ3]
			default:            cond_met = 1'b0;
		endcase
	endfunction

	// field split of the issued word
	wire [2:0]  class_field     = instr_i[branch_pkg::CLASS_MSB:branch_pkg::CLASS_LSB];   // [RQ4]
	wire [3:0]  operation_field = instr_i[branch_pkg::OPF_MSB:branch_pkg::OPF_LSB];       // [RQ4]
	wire        delay_flag      = instr_i[branch_pkg::DELAY_BIT];                          // [RQ4]
	wire [7:0]  short_displacement = instr_i[branch_pkg::DISP_MSB:0];                      // [RQ4]

	// decode: only our three operations in the branch class
	wire op_ours = (operation_field == branch_pkg::OPF_GE) ||
		(operation_field == branch_pkg::OPF_GT) || (operation_field == branch_pkg::OPF_LE);
	wire decoded = (class_field == branch_pkg::CLASS_BRANCH) && op_ours;  // [RQ4]
	// a branch placed in a slot is undefined; it is simply not started there
	wire accept  = instr_valid_i && decoded && (state == ST_IDLE);
	wire take    = cond_met(operation_field, flags_i);
	wire slot_issue = instr_valid_i && (state == ST_SLOT);               // [RQ11]

	// target arithmetic
	wire [31:0] offset;                        // signed byte offset
	wire [31:0] next_target = pc_i + offset;   // [RQ5] [RQ9] [RQ10]

	disp_former u_disp (
		.short_displacement_i (short_displacement),
		.prefix_count_i       (prefix_count),
		.prefix_hi_i          (prefix_hi),
		.prefix_lo_i          (prefix_lo),
		.offset_o             (offset)
	);

	// state transitions
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept && delay_flag)
					next_state = ST_SLOT;     // [RQ8] done now, slot follows
				else if (accept && take)
					next_state = ST_TAKEN;    // [RQ7] one extra cycle
			end
			ST_TAKEN: next_state = ST_IDLE;       // [RQ7]
			ST_SLOT: begin
				if (slot_issue)
					next_state = ST_IDLE;     // [RQ11] slot has run
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// prefix collection; any other instruction ends the prefix run
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prefix_count <= branch_pkg::PFX_NONE;
			prefix_hi    <= '0;
			prefix_lo    <= '0;
		end else if (prefix_valid_i) begin
			// keep the last two; a third prefix pushes the oldest out
			prefix_hi    <= prefix_lo;                    // [RQ10]
			prefix_lo    <= prefix_payload_i;             // [RQ9]
			prefix_count <= (prefix_count == branch_pkg::PFX_NONE) ? branch_pkg::PFX_ONE :
				branch_pkg::PFX_TWO;
		end else if (instr_valid_i) begin
			prefix_count <= branch_pkg::PFX_NONE;
		end
	end

	// target and outcome capture at acceptance
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			target     <= branch_pkg::RESET_WORD;
			pend_taken <= 1'b0;
			last_taken <= 1'b0;
		end else if (accept) begin
			target     <= next_target;
			pend_taken <= take && delay_flag;
			last_taken <= take;
		end
	end

	// taken counter: a taken branch in the cycle of a clearing write still counts
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			taken_count <= branch_pkg::RESET_WORD;
		else if (accept && take && reg_we_i && (reg_addr_i == branch_pkg::REG_TAKEN_COUNT))
			taken_count <= 32'h0000_0001;
		else if (reg_we_i && (reg_addr_i == branch_pkg::REG_TAKEN_COUNT))
			taken_count <= 32'h0000_0000;
		else if (accept && take)
			taken_count <= taken_count + 32'h0000_0001;
	end

	// core-facing outputs; redirect for a delayed branch lands with the slot
	assign redirect_o.valid  = (state == ST_TAKEN) ||
		(slot_issue && pend_taken);                                       // [RQ7] [RQ11]
	assign redirect_o.target = target;
	assign is_branch_o = accept;
	assign busy_o      = (state == ST_TAKEN);                             // [RQ7]
	// masked from the cycle after the branch up to and including slot issue
	assign trap_mask_o = (state == ST_SLOT);                              // [RQ12]
	// relies on software keeping the slot legal; nothing here checks it    [RQ13]
	assign flags_we_o  = 1'b0;                                            // [RQ14]

	// register read selection
	wire [31:0] status_word = {29'h0000_0000, last_taken, busy_o, trap_mask_o};
	wire [31:0] read_mux =
		(reg_addr_i == branch_pkg::REG_STATUS)      ? status_word :
		(reg_addr_i == branch_pkg::REG_LAST_TARGET) ? target      :
		(reg_addr_i == branch_pkg::REG_TAKEN_COUNT) ? taken_count : 32'h0000_0000;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata <= branch_pkg::RESET_WORD;
		else if (reg_re_i)
			rdata <= read_mux;
		else
			rdata <= 32'h0000_0000;
	end
	assign reg_rdata_o = rdata;

	// write data unused beyond the clearing strobe
	wire unused_wdata = ^reg_wdata_i;

endmodule // signed_cond_branch_unit

/* File: tb/signed_cond_branch_unit_properties.sv */
// checker: port-level properties of the signed conditional branch unit
`timescale 1ns/100ps
module signed_cond_branch_unit_properties (
	// clock, reset and issue
	input wire logic               clk_i,
	input wire logic               rstn_i,
	input wire logic               instr_valid_i,
	input wire logic [15:0]        instr_i,
	input wire logic [31:0]        pc_i,
	input wire branch_pkg::flags_t flags_i,
	input wire logic               prefix_valid_i,
	// core control and register read
	input wire branch_pkg::redirect_t redirect_o,
	input wire logic               is_branch_o,
	input wire logic               busy_o,
	input wire logic               trap_mask_o,
	input wire logic               flags_we_o,
	input wire logic               reg_re_i,
	input wire logic [31:0]        reg_rdata_o
);
	wire logic [3:0]  opf   = instr_i[12:9];              // operation field
	wire logic        nv    = flags_i.n ^ flags_i.v;      // signed less-than
	wire logic        dly   = instr_i[8];                 // delayed form
	wire logic        dec   = instr_i[15:13] == 3'h0 && (opf == branch_pkg::OPF_GE ||
		opf == branch_pkg::OPF_GT || opf == branch_pkg::OPF_LE);
	wire logic        cond  = (opf == branch_pkg::OPF_GE && !nv) ||
		(opf == branch_pkg::OPF_GT && !flags_i.z && !nv) ||
		(opf == branch_pkg::OPF_LE && (flags_i.z || nv));
	wire logic [31:0] sdisp = {{23{instr_i[7]}}, instr_i[7:0], 1'h0}; // short form only
	logic             pend;                                 // a prefix waits for its branch
	// track pending prefixes so the short-form check skips widened offsets
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			pend <= 1'b0;
		else if (prefix_valid_i)
			pend <= 1'b1;
		else if (instr_valid_i)
			pend <= 1'b0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	chk_flags_kept: assert property (!flags_we_o)
		else $error("status flags written by a branch");
	chk_decode_match: assert property (is_branch_o == (instr_valid_i && !busy_o && !trap_mask_o && dec))
		else $error("branch decode wrong");
	chk_plain_taken: assert property (is_branch_o && !dly && cond |=> busy_o && redirect_o.valid)
		else $error("taken plain branch lacks second cycle");
	chk_plain_fail: assert property (is_branch_o && !dly && !cond |=> !busy_o && !redirect_o.valid)
		else $error("failed plain branch took extra cycle");
	chk_short_target: assert property (is_branch_o && !pend && !dly && cond |=>
		redirect_o.target == $past(pc_i) + $past(sdisp))
		else $error("short target wrong");
	chk_delay_one: assert property (is_branch_o && dly |=> trap_mask_o && !busy_o && (redirect_o.valid == (instr_valid_i && $past(cond))))
		else $error("delayed branch not one cycle");
	chk_mask_hold: assert property (trap_mask_o && !instr_valid_i |=> trap_mask_o)
		else $error("trap mask dropped before slot");
	chk_slot_release: assert property (trap_mask_o && instr_valid_i |=> !trap_mask_o)
		else $error("trap mask held past slot");
	chk_read_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	cov_taken: cover property (is_branch_o && !dly && cond);
	cov_slot: cover property (trap_mask_o && instr_valid_i);
	cov_prefixed: cover property (is_branch_o && pend);
endmodule // signed_cond_branch_unit_properties
bind signed_cond_branch_unit signed_cond_branch_unit_properties u_props (.clk_i(clk_i),
	.rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
	.flags_i(flags_i), .prefix_valid_i(prefix_valid_i), .redirect_o(redirect_o),
	.is_branch_o(is_branch_o), .busy_o(busy_o), .trap_mask_o(trap_mask_o),
	.flags_we_o(flags_we_o), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

/* File: tb/signed_cond_branch_unit_tb.sv */
// testbench: scenario tasks for the signed conditional branch unit
`timescale 1ns/100ps
module signed_cond_branch_unit_tb;
	localparam logic [31:0] PC = 32'h0040_0000;      // issue address, even
	logic clk_i, rstn_i, instr_valid_i, prefix_valid_i, reg_we_i, reg_re_i;
	logic [15:0] instr_i;                            // instruction word
	logic [12:0] prefix_payload_i;                   // prefix payload
	logic [31:0] pc_i, reg_wdata_i, e_tgt;           // e_tgt: last expected target
	logic [3:0]  reg_addr_i;                         // register address
	branch_pkg::flags_t    flags_i;                  // condition flags
	branch_pkg::redirect_t redirect_o;               // redirect toward fetch
	logic is_branch_o, busy_o, trap_mask_o, flags_we_o, t;
	logic [31:0] reg_rdata_o;                        // read data
	int failures = 0, n_compared = 0;                // mismatch and compare counts
	signed_cond_branch_unit u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i), .flags_i(flags_i),
		.prefix_valid_i(prefix_valid_i), .prefix_payload_i(prefix_payload_i),
		.redirect_o(redirect_o), .is_branch_o(is_branch_o), .busy_o(busy_o),
		.trap_mask_o(trap_mask_o), .flags_we_o(flags_we_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o));
	// 100 MHz core clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// expected outcome of the three signed conditions
	function automatic logic cnd(logic [3:0] op, logic [2:0] f);
		case (op)
			branch_pkg::OPF_GE: return !(f[2] ^ f[0]);
			branch_pkg::OPF_GT: return !f[1] && !(f[2] ^ f[0]);
			default: return f[1] || (f[2] ^ f[0]);
		endcase
	endfunction
	// byte offset for none, one or two prefixes; bit 0 is always zero
	function automatic logic [31:0] off(int np, logic [12:0] p1, logic [12:0] p2, logic [7:0] d);
		if (np == 0)
			return {{23{d[7]}}, d, 1'h0};
		if (np == 1)
			return {{10{p2[12]}}, p2, d, 1'h0};
		return {p1[12:3], p2, d, 1'h0};
	endfunction
	task automatic pfx(logic [12:0] p);
		@(posedge clk_i);
		prefix_valid_i <= 1'b1;
		prefix_payload_i <= p;
	endtask
	// issue one branch with optional prefixes, judge the cycle after issue
	task automatic br(logic [3:0] op, logic dl, logic [2:0] f, logic [7:0] d, int np,
		logic [12:0] p1, logic [12:0] p2);
		if (np > 1)
			pfx(p1);
		if (np > 0)
			pfx(p2);
		t = cnd(op, f);
		e_tgt = PC + off(np, p1, p2, d);
		@(posedge clk_i);
		prefix_valid_i <= 1'b0;
		instr_valid_i <= 1'b1;
		instr_i <= {3'h0, op, dl, d};
		flags_i <= '{f[2], f[1], f[0], 1'b0};
		#1 chk("is_branch", 1, is_branch_o);
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1 chk("busy", t & !dl, busy_o);
		chk("redirect", t & !dl, redirect_o.valid);
		chk("mask", dl, trap_mask_o);
		chk("flags_we", 0, flags_we_o);
		if (t && !dl)
			chk("target", e_tgt, redirect_o.target);
	endtask
	task automatic reg_rd(logic [3:0] a, logic [31:0] e);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 chk("rdata", e, reg_rdata_o);
	endtask
	// every condition against all N, Z, V combinations (carry held at zero), both displacement extremes
	task automatic t_cond();
		logic [3:0] ops [3] = '{branch_pkg::OPF_GE, branch_pkg::OPF_GT, branch_pkg::OPF_LE};
		for (int i = 0; i < 3; i++)
			for (int f = 0; f < 8; f++)
				br(ops[i], 1'b0, f[2:0], f[0] ? 8'h7F : 8'h80, 0, 13'h0, 13'h0);
	endtask
	// delayed form taken and not taken: mask waits for the slot, redirect in slot
	task automatic t_delay();
		for (int k = 0; k < 2; k++) begin
			br(branch_pkg::OPF_GT, 1'b1, k ? 3'h2 : 3'h0, 8'h05, 0, 13'h0, 13'h0);
			@(posedge clk_i);
			#1 chk("mask_wait", 1, trap_mask_o);
			@(posedge clk_i);
			instr_valid_i <= 1'b1;
			instr_i <= 16'hE000;
			#1 chk("slot_redirect", !k, redirect_o.valid);
			chk("slot_not_branch", 0, is_branch_o);
			if (!k)
				chk("slot_target", e_tgt, redirect_o.target);
			@(posedge clk_i);
			instr_valid_i <= 1'b0;
			#1 chk("mask_drop", 0, trap_mask_o);
		end
	endtask
	// register port: clear count, take one branch, read back, unmapped read
	task automatic t_regs();
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= branch_pkg::REG_TAKEN_COUNT;
		reg_wdata_i <= 32'hFFFF_FFFF;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		br(branch_pkg::OPF_GE, 1'b0, 3'h0, 8'h10, 0, 13'h0, 13'h0);
		reg_rd(branch_pkg::REG_LAST_TARGET, e_tgt);
		reg_rd(branch_pkg::REG_TAKEN_COUNT, 32'h1);
		reg_rd(branch_pkg::REG_STATUS, 32'h4);
		reg_rd(4'hC, 32'h0);
	endtask
	// reset, then scenarios
	initial begin
		{rstn_i, instr_valid_i, prefix_valid_i, reg_we_i, reg_re_i} = '0;
		{instr_i, prefix_payload_i, reg_wdata_i, reg_addr_i} = '0;
		flags_i = '0;
		pc_i = PC;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_cond();
		br(branch_pkg::OPF_GE, 1'b0, 3'h0, 8'h01, 1, 13'h0, 13'h1000);
		br(branch_pkg::OPF_LE, 1'b0, 3'h2, 8'hFF, 2, 13'h1ABF, 13'h0123);
		t_delay();
		t_regs();
		print_verdict();
	end
	// watchdog: the run needs about 80 cycles
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
endmodule // signed_cond_branch_unit_tb
